// file: logic/gpb_pkg.sv
// Package for the instrument-side general purpose parallel bus port.
// Assumes one system clock at 25 MHz and a synchronous active-high reset.
package gpb_pkg;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned FIFO_DEPTH = 32;
    localparam int unsigned SYNC_W     = 7;
    localparam logic [1:0]  SYNC_RST   = 2'h3;
    localparam logic [7:0]  BYTE_ZERO  = 8'h00;

    // Bus control lines as seen at the pins, all low-true
    typedef struct packed {
        logic atn_n;
        logic dav_n;
        logic nrfd;
        logic ndac;
        logic eoi_n;
        logic ifc_n;
        logic ren_n;
    } gpb_ctl_t;

    // Byte with its end-of-message mark
    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } gpb_word_t;

    typedef enum logic [2:0] {
        GPB_IDLE, GPB_WAIT_NRFD, GPB_WAIT_NDAC, GPB_WAIT_DAV_HI
    } gpb_src_t;

    typedef enum logic [2:0] {
        GPB_AIDLE, GPB_LATCH, GPB_WAIT_DAV_REL
    } gpb_acc_t;

    // Converts a line level to the logical byte and back
    function automatic logic [7:0] gpb_invert(input logic [7:0] v);
        return ~v;
    endfunction
endpackage

// file: logic/gpb_fifo.sv
// FIFO with valid and ready on both sides.
// Assumes one clock, synchronous active-high reset and a clock enable.
`timescale 1ns/1ps
module gpb_fifo #(
    parameter int unsigned WIDTH = 9,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst,
    input  wire logic             i_ce,
    input  wire logic             i_flush,
    input  wire logic [WIDTH-1:0] i_wr_data,
    input  wire logic             i_wr_valid,
    output logic                  o_wr_ready,
    output logic [WIDTH-1:0]      o_rd_data,
    output logic                  o_rd_valid,
    input  wire logic             i_rd_ready
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } gpb_fifo_st_t;

    logic [WIDTH-1:0] mem [DEPTH];
    gpb_fifo_st_t     s_q;
    gpb_fifo_st_t     s_d;
    logic             full;
    logic             empty;
    logic             do_wr;
    logic             do_rd;

    assign full       = (s_q.wp[AW] != s_q.rp[AW]) && (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]);
    assign empty      = (s_q.wp == s_q.rp);
    assign do_wr      = i_wr_valid && !full;
    assign do_rd      = i_rd_ready && !empty;
    assign o_wr_ready = !full;
    assign o_rd_valid = !empty;
    assign o_rd_data  = mem[s_q.rp[AW-1:0]];

    always_comb begin
        s_d = s_q;
        if (do_wr) begin
            s_d.wp = s_q.wp + 1'b1;
        end
        if (do_rd) begin
            s_d.rp = s_q.rp + 1'b1;
        end
        if (i_flush) begin
            s_d = '0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            s_q <= '0;
        end else if (i_ce) begin
            s_q <= s_d;
            if (do_wr) begin
                mem[s_q.wp[AW-1:0]] <= i_wr_data;
            end
        end
    end
endmodule

// file: logic/gpb_port.sv
// Instrument-side bus port: talker source and listener acceptor handshakes.
// Assumes pins are resolved outside; data pins input, output and enable; DAV, NRFD, NDAC, EOI input and enable; ATN, IFC, REN input only; SRQ enable only.
`timescale 1ns/1ps
module gpb_port (
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst,
    input  wire logic             i_ce,
    input  wire gpb_pkg::gpb_ctl_t i_ctl,
    input  wire logic [7:0]       i_dio,
    output logic [7:0]            o_dio,
    output logic                  o_dio_oe,
    output logic                  o_dav_oe,
    output logic                  o_nrfd_oe,
    output logic                  o_ndac_oe,
    output logic                  o_eoi_oe,
    output logic                  o_srq_oe,
    input  wire logic             i_talk_en,
    input  wire logic             i_listen_en,
    input  wire logic             i_srq_need,
    input  wire gpb_pkg::gpb_word_t i_tx,
    input  wire logic             i_tx_valid,
    output logic                  o_tx_ready,
    output gpb_pkg::gpb_word_t    o_rx,
    output logic                  o_rx_valid,
    input  wire logic             i_rx_ready,
    output logic [7:0]            o_cmd,
    output logic                  o_cmd_valid,
    output logic                  o_ppoll_req,
    output logic                  o_remote,
    output logic                  o_ifc_seen
);
    import gpb_pkg::*;

    typedef struct packed {
        gpb_ctl_t   s1;
        gpb_ctl_t   s2;
        gpb_src_t   src;
        gpb_acc_t   acc;
        logic       talk;
        logic       listen;
        gpb_word_t  txw;
        logic [7:0] dio;
        logic       dio_oe;
        logic       dav_oe;
        logic       nrfd_oe;
        logic       ndac_oe;
        logic       eoi_oe;
        logic       srq_oe;
        logic       tx_ready;
        gpb_word_t  rxw;
        logic       rx_valid;
        logic [7:0] cmd;
        logic       cmd_valid;
        logic       ppoll;
        logic       remote;
        logic       ifc;
    } gpb_st_t;

    gpb_st_t   s_q;
    gpb_st_t   s_d;
    gpb_word_t ff_out;
    logic      ff_valid;
    logic      ff_pop;
    logic      ff_in_ready;
    logic      ff_push;
    logic      ifc_act;
    gpb_word_t rx_q;
    logic      rxv_q;

    assign ifc_act = !s_q.s2.ifc_n;

    gpb_fifo #(.WIDTH(DATA_W + 1), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .i_clk_sys  (i_clk_sys),
        .i_rst      (i_rst),
        .i_ce       (i_ce),
        .i_flush    (ifc_act),
        .i_wr_data  (s_q.rxw),
        .i_wr_valid (ff_push),
        .o_wr_ready (ff_in_ready),
        .o_rd_data  (ff_out),
        .o_rd_valid (ff_valid),
        .i_rd_ready (ff_pop)
    );

    assign ff_push = s_q.rx_valid;
    // Refill the output register only when it is empty or being taken
    assign ff_pop  = ff_valid && (!rxv_q || i_rx_ready);

    always_comb begin
        s_d           = s_q;
        s_d.s1        = i_ctl;
        s_d.s2        = s_q.s1;
        s_d.cmd_valid = 1'b0;
        s_d.tx_ready  = 1'b0;
        s_d.srq_oe    = i_srq_need;
        s_d.remote    = !s_q.s2.ren_n;
        s_d.ppoll     = !s_q.s2.atn_n && !s_q.s2.eoi_n;
        s_d.ifc       = ifc_act;
        s_d.talk      = i_talk_en;
        s_d.listen    = i_listen_en;
        if (ff_push) begin
            s_d.rx_valid = 1'b0;
        end

        // Source handshake
        case (s_q.src)
            GPB_IDLE: begin
                s_d.dav_oe = 1'b0;
                if (s_q.talk && s_q.s2.atn_n && i_tx_valid) begin
                    s_d.txw      = i_tx;
                    s_d.dio      = gpb_invert(i_tx.data);
                    s_d.dio_oe   = 1'b1;
                    s_d.eoi_oe   = i_tx.last;
                    s_d.tx_ready = 1'b1;
                    s_d.src      = GPB_WAIT_NRFD;
                end else begin
                    s_d.dio_oe = 1'b0;
                    s_d.eoi_oe = 1'b0;
                end
            end
            GPB_WAIT_NRFD: begin
                if (s_q.s2.nrfd) begin
                    s_d.dav_oe = 1'b1;
                    s_d.src    = GPB_WAIT_NDAC;
                end
            end
            GPB_WAIT_NDAC: begin
                if (s_q.s2.ndac) begin
                    s_d.dav_oe = 1'b0;
                    s_d.src    = GPB_WAIT_DAV_HI;
                end
            end
            GPB_WAIT_DAV_HI: begin
                s_d.dio_oe = 1'b0;
                s_d.eoi_oe = 1'b0;
                s_d.src    = GPB_IDLE;
            end
            default: s_d.src = GPB_IDLE;
        endcase

        // Acceptor handshake
        case (s_q.acc)
            GPB_AIDLE: begin
                s_d.ndac_oe = s_q.listen || !s_q.s2.atn_n;
                s_d.nrfd_oe = !(ff_in_ready && !s_q.rx_valid);
                if (!s_q.s2.dav_n && !s_q.nrfd_oe && (s_q.listen || !s_q.s2.atn_n)) begin
                    s_d.nrfd_oe = 1'b1;
                    s_d.acc     = GPB_LATCH;
                end
            end
            GPB_LATCH: begin
                if (!s_q.s2.atn_n) begin
                    s_d.cmd       = gpb_invert(i_dio);
                    s_d.cmd_valid = 1'b1;
                end else begin
                    s_d.rxw.data  = gpb_invert(i_dio);
                    s_d.rxw.last  = !s_q.s2.eoi_n;
                    s_d.rx_valid  = 1'b1;
                end
                s_d.ndac_oe = 1'b0;
                s_d.acc     = GPB_WAIT_DAV_REL;
            end
            GPB_WAIT_DAV_REL: begin
                if (s_q.s2.dav_n) begin
                    s_d.ndac_oe = 1'b1;
                    s_d.acc     = GPB_AIDLE;
                end
            end
            default: s_d.acc = GPB_AIDLE;
        endcase

        if (ifc_act) begin
            s_d.src      = GPB_IDLE;
            s_d.acc      = GPB_AIDLE;
            s_d.talk     = 1'b0;
            s_d.listen   = 1'b0;
            s_d.dav_oe   = 1'b0;
            s_d.dio_oe   = 1'b0;
            s_d.eoi_oe   = 1'b0;
            s_d.nrfd_oe  = 1'b0;
            s_d.ndac_oe  = 1'b0;
            s_d.rx_valid = 1'b0;
            s_d.tx_ready = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            s_q         <= '0;
            s_q.s1      <= '1;
            s_q.s2      <= '1;
            s_q.s1.nrfd <= 1'b0;
            s_q.s2.nrfd <= 1'b0;
            s_q.s1.ndac <= 1'b0;
            s_q.s2.ndac <= 1'b0;
            s_q.src     <= GPB_IDLE;
            s_q.acc     <= GPB_AIDLE;
            s_q.dio     <= BYTE_ZERO;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    // Received byte output register
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || (i_ce && ifc_act)) begin
            rx_q  <= '0;
            rxv_q <= 1'b0;
        end else if (i_ce) begin
            if (ff_pop) begin
                rx_q  <= ff_out;
                rxv_q <= 1'b1;
            end else if (i_rx_ready) begin
                rxv_q <= 1'b0;
            end
        end
    end

    assign o_dio       = s_q.dio;
    assign o_dio_oe    = s_q.dio_oe;
    assign o_dav_oe    = s_q.dav_oe;
    assign o_nrfd_oe   = s_q.nrfd_oe;
    assign o_ndac_oe   = s_q.ndac_oe;
    assign o_eoi_oe    = s_q.eoi_oe;
    assign o_srq_oe    = s_q.srq_oe;
    assign o_tx_ready  = s_q.tx_ready;
    assign o_rx        = rx_q;
    assign o_rx_valid  = rxv_q;
    assign o_cmd       = s_q.cmd;
    assign o_cmd_valid = s_q.cmd_valid;
    assign o_ppoll_req = s_q.ppoll;
    assign o_remote    = s_q.remote;
    assign o_ifc_seen  = s_q.ifc;
endmodule

// file: tb/gpb_props.sv
// Checker for the bus port handshake, bound to gpb_port.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/1ps
module gpb_props (
    input wire logic               i_clk_sys,
    input wire logic               i_rst,
    input wire gpb_pkg::gpb_ctl_t  i_ctl,
    input wire gpb_pkg::gpb_word_t i_tx,
    input wire logic               i_srq_need,
    input wire logic [7:0]         o_dio,
    input wire logic               o_dio_oe,
    input wire logic               o_dav_oe,
    input wire logic               o_eoi_oe,
    input wire logic               o_srq_oe,
    input wire logic               o_remote,
    input wire logic               o_ppoll_req,
    input wire logic               o_ifc_seen
);
    import gpb_pkg::*;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    a_dav_after_rfd: assert property ($rose(o_dav_oe) |-> i_ctl.nrfd && o_dio_oe)
        else $error("dav early");
    a_data_held: assert property (o_dav_oe && $past(o_dav_oe) |-> $stable(o_dio) && o_dio_oe)
        else $error("data moved");
    a_dav_rel_ndac: assert property ($fell(o_dav_oe) |-> i_ctl.ndac || !i_ctl.ifc_n)
        else $error("dav released early");
    a_tx_inverted: assert property ($rose(o_dio_oe) |-> o_dio == ~$past(i_tx.data)
        && o_eoi_oe == $past(i_tx.last)) else $error("tx byte wrong");
    a_ifc_aborts: assert property (!i_ctl.ifc_n [*5] |-> o_ifc_seen && !o_dav_oe && !o_dio_oe)
        else $error("ifc no abort");
    a_remote_follows: assert property ($stable(i_ctl.ren_n) [*5] |-> o_remote == !i_ctl.ren_n)
        else $error("remote wrong");
    a_srq_follows: assert property ($stable(i_srq_need) [*4] |-> o_srq_oe == i_srq_need)
        else $error("srq wrong");
    a_ppoll_decode: assert property ($stable({i_ctl.atn_n, i_ctl.eoi_n}) [*5]
        |-> o_ppoll_req == (!i_ctl.atn_n && !i_ctl.eoi_n)) else $error("ppoll wrong");
    c_talk: cover property ($rose(o_dav_oe));
    c_ifc: cover property ($rose(o_ifc_seen));
    c_ppoll: cover property ($rose(o_ppoll_req));
endmodule
bind gpb_port gpb_props i_props (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ctl(i_ctl),
    .i_tx(i_tx), .i_srq_need(i_srq_need), .o_dio(o_dio), .o_dio_oe(o_dio_oe),
    .o_dav_oe(o_dav_oe), .o_eoi_oe(o_eoi_oe), .o_srq_oe(o_srq_oe), .o_remote(o_remote),
    .o_ppoll_req(o_ppoll_req), .o_ifc_seen(o_ifc_seen));

// file: tb/gpb_ctrl_model.sv
// Controller model at the far side of the bus port.
// Assumes it sees the port's enables; it resolves every open-drain line except SRQ.
`timescale 1ns/1ps
module gpb_ctrl_model (
    input  wire logic         i_clk_sys,
    input  wire logic [7:0]   i_dio,
    input  wire logic         i_dio_oe,
    input  wire logic         i_dav_oe,
    input  wire logic         i_nrfd_oe,
    input  wire logic         i_ndac_oe,
    input  wire logic         i_eoi_oe,
    output gpb_pkg::gpb_ctl_t o_ctl,
    output logic [7:0]        o_dio
);
    import gpb_pkg::*;
    // Pull-low requests; released lines float high
    logic atn = 0, dav = 0, nrfd = 1, ndac = 1, eoi = 0, ifc = 0, ren = 0, c_oe = 0;
    logic [7:0] c_dio = 8'h00;
    assign o_ctl = '{atn_n: !atn, dav_n: !(dav | i_dav_oe), nrfd: !(nrfd | i_nrfd_oe),
        ndac: !(ndac | i_ndac_oe), eoi_n: !(eoi | i_eoi_oe), ifc_n: !ifc,
        ren_n: !ren};
    assign o_dio = (i_dio_oe ? i_dio : 8'hff) & (c_oe ? c_dio : 8'hff);
    // Sources one byte; ok low if ready never came
    task automatic send(input logic [7:0] b, input logic l, output logic ok);
        int n;
        n = 0;
        @(posedge i_clk_sys);
        nrfd <= 0;
        ndac <= 0;
        @(posedge i_clk_sys);
        while (!o_ctl.nrfd && n < 12) begin
            @(posedge i_clk_sys);
            n++;
        end
        ok = o_ctl.nrfd;
        if (ok) begin
            c_dio <= ~b;
            c_oe <= 1;
            eoi <= l;
            @(posedge i_clk_sys);
            dav <= 1;
            do @(posedge i_clk_sys); while (!o_ctl.ndac);
            dav <= 0;
            @(posedge i_clk_sys);
            c_oe <= 0;
            eoi <= 0;
        end
        nrfd <= 1;
        ndac <= 1;
    endtask
    // Accepts one byte after d+1 cycles not ready
    task automatic recv(input int d, output logic [8:0] w);
        repeat (d + 1) @(posedge i_clk_sys);
        nrfd <= 0;
        do @(posedge i_clk_sys); while (o_ctl.dav_n);
        w = {!o_ctl.eoi_n, ~o_dio};
        nrfd <= 1;
        @(posedge i_clk_sys);
        ndac <= 0;
        do @(posedge i_clk_sys); while (!o_ctl.dav_n);
        ndac <= 1;
    endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench for the bus port against the controller model.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ps
module testbench;
    import gpb_pkg::*;
    logic clk = 0, rst = 1, talk_en = 0, listen_en = 0, srq_need = 0, tx_valid = 0;
    logic rx_ready = 0;
    gpb_word_t tx = '0;
    gpb_word_t rx;
    gpb_ctl_t ctl;
    logic [7:0] dio, dio_out, cmd;
    logic dio_oe, dav_oe, nrfd_oe, ndac_oe, eoi_oe, srq_oe, tx_ready, rx_valid;
    logic cmd_valid, ppoll, remote, ifc_seen;
    int mismatches = 0, samples_checked = 0;
    always #20 clk = ~clk;
    gpb_port i_dut (.i_clk_sys(clk), .i_rst(rst), .i_ce(1'b1), .i_ctl(ctl), .i_dio(dio),
        .o_dio(dio_out), .o_dio_oe(dio_oe), .o_dav_oe(dav_oe), .o_nrfd_oe(nrfd_oe),
        .o_ndac_oe(ndac_oe), .o_eoi_oe(eoi_oe), .o_srq_oe(srq_oe), .i_talk_en(talk_en),
        .i_listen_en(listen_en), .i_srq_need(srq_need), .i_tx(tx), .i_tx_valid(tx_valid),
        .o_tx_ready(tx_ready), .o_rx(rx), .o_rx_valid(rx_valid), .i_rx_ready(rx_ready),
        .o_cmd(cmd), .o_cmd_valid(cmd_valid), .o_ppoll_req(ppoll), .o_remote(remote),
        .o_ifc_seen(ifc_seen));
    gpb_ctrl_model i_ctrl (.i_clk_sys(clk), .i_dio(dio_out), .i_dio_oe(dio_oe),
        .i_dav_oe(dav_oe), .i_nrfd_oe(nrfd_oe), .i_ndac_oe(ndac_oe), .i_eoi_oe(eoi_oe),
        .o_ctl(ctl), .o_dio(dio));
    task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        if (mismatches == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic put(input logic [8:0] w);
        @(posedge clk);
        tx <= gpb_word_t'(w);
        tx_valid <= 1;
        do @(posedge clk); while (!tx_ready);
        tx_valid <= 0;
    endtask
    task automatic pop(input logic [8:0] e);
        do @(posedge clk); while (!rx_valid);
        chk("rx", {rx.last, rx.data}, e);
        rx_ready <= 1;
        @(posedge clk);
        rx_ready <= 0;
    endtask
    task automatic t_talk();
        logic [8:0] w;
        listen_en <= 0;
        talk_en <= 1;
        fork
            begin put(9'h03c); put(9'h1a5); end
            begin
                i_ctrl.recv(0, w);
                chk("talk0", w, 9'h03c);
                i_ctrl.recv(6, w);
                chk("talk1", w, 9'h1a5);
            end
        join
        talk_en <= 0;
    endtask
    task automatic t_cmd();
        logic ok;
        listen_en <= 1;
        i_ctrl.atn <= 1;
        fork
            i_ctrl.send(8'h3f, 1'b0, ok);
            begin
                do @(posedge clk); while (!cmd_valid);
                chk("cmd", {1'b0, cmd}, 9'h03f);
            end
        join
        @(posedge clk);
        i_ctrl.eoi <= 1;
        repeat (5) @(posedge clk);
        chk("ppoll_rx", {7'h00, ppoll, rx_valid}, 9'h002);
        i_ctrl.atn <= 0;
        repeat (5) @(posedge clk);
        chk("ppoll_off", {8'h00, ppoll}, 9'h000);
        i_ctrl.eoi <= 0;
    endtask
    task automatic t_fill();
        logic ok;
        int n;
        n = 0;
        ok = 1;
        while (ok && n < 40) begin
            i_ctrl.send(8'h5a ^ 8'(n), n[0], ok);
            if (ok) n++;
        end
        chk("fill", 9'(n), 9'(FIFO_DEPTH + 1));
        chk("held", {8'h00, nrfd_oe}, 9'h001);
        for (int i = 0; i < n; i++) pop({i[0], 8'h5a ^ 8'(i)});
    endtask
    task automatic t_ifc();
        logic ok;
        i_ctrl.ren <= 1;
        srq_need <= 1;
        repeat (5) @(posedge clk);
        chk("rem_srq", {7'h00, remote, srq_oe}, 9'h003);
        i_ctrl.ren <= 0;
        srq_need <= 0;
        i_ctrl.send(8'h81, 1'b1, ok);
        chk("local", {7'h00, remote, srq_oe}, 9'h000);
        listen_en <= 0;
        talk_en <= 1;
        put(9'h042);
        i_ctrl.nrfd <= 0;
        repeat (6) @(posedge clk);
        chk("dav_on", {8'h00, dav_oe}, 9'h001);
        i_ctrl.ifc <= 1;
        talk_en <= 0;
        repeat (6) @(posedge clk);
        chk("abort", {5'h00, ifc_seen, dav_oe, dio_oe, rx_valid}, 9'h008);
        i_ctrl.ifc <= 0;
        i_ctrl.nrfd <= 1;
        repeat (6) @(posedge clk);
        chk("ifc_off", {8'h00, ifc_seen}, 9'h000);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 0;
        t_talk();
        t_cmd();
        t_fill();
        t_ifc();
        conclude();
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        conclude();
    end
endmodule
